/* pkg/gpc_regs.vh */
// Register offsets, field positions, reset values and function codes of the pin control block
`ifndef GPC_REGS_VH
`define GPC_REGS_VH

`define GPC_ADDR_W          7
`define GPC_DATA_W          16

`define GPC_PIN_THREE_CTRL  7'h0E
`define GPC_PIN_FOUR_CTRL   7'h0F
`define GPC_IRQ_STATUS      7'h10

`define GPC_DIR_BIT         15
`define GPC_PULL_HI         14
`define GPC_PULL_LO         13
`define GPC_MODE_BIT        12
`define GPC_INV_BIT         10
`define GPC_LVL_BIT         5
`define GPC_FN_HI           3
`define GPC_FN_LO           0

`define GPC_PIN3_FLAG_BIT   13
`define GPC_PIN4_FLAG_BIT   14

// Writable bits of a control word: 15:12, 10, 5, 3:0
`define GPC_CTRL_MASK       16'hF42F
`define GPC_PIN_THREE_RST   16'hC000
`define GPC_PIN_FOUR_RST    16'h8000

`define GPC_PULL_NONE       2'h0
`define GPC_PULL_DOWN       2'h1
`define GPC_PULL_UP         2'h2

`define GPC_FN_LEVEL_IN     4'h0
`define GPC_FN_EDGE_IN      4'h1
`define GPC_FN_CLK_OUT      4'h2
`define GPC_FN_IRQ_OUT      4'h3
`define GPC_FN_PEN_DOWN     4'h4
`define GPC_FN_TOUCH_DONE   4'h5
`define GPC_FN_AUX_DONE     4'h6
`define GPC_FN_TEMP_FLAG    4'h7
`define GPC_FN_MIC_CLK      4'h9
`define GPC_FN_LEVEL_OUT    4'hA
`define GPC_FN_UNDERVOLT    4'hB

`endif

/* logic/gpc_pin_slice.v */
// One general-purpose pin: function mux, polarity, pulls, level readback and edge detection
`timescale 1ns/1ps
`include "gpc_regs.vh"

module gpc_pin_slice (
    input  wire        i_core_clk,
    input  wire        i_reset,
    input  wire [15:0] i_ctrl,
    input  wire        i_pin_in,
    input  wire        i_clock_output,
    input  wire        i_irq,
    input  wire        i_pen_down,
    input  wire        i_touch_done,
    input  wire        i_aux_done,
    input  wire        i_temp_flag,
    input  wire        i_digital_mic_clock,
    input  wire        i_regulator_undervoltage,
    output reg         o_pin_out,
    output reg         o_pin_oe,
    output reg         o_pull_up,
    output reg         o_pull_down,
    output wire        o_level,
    output wire        o_edge_event
);

    wire [3:0] function_select;
    wire [1:0] pull_select;
    wire       direction;
    wire       edge_mode;
    wire       invert;
    wire       level_bit;
    reg        source;
    reg        prev_level_ff;

    assign function_select = i_ctrl[`GPC_FN_HI:`GPC_FN_LO];
    assign pull_select     = i_ctrl[`GPC_PULL_HI:`GPC_PULL_LO];
    assign direction       = i_ctrl[`GPC_DIR_BIT];
    assign edge_mode       = i_ctrl[`GPC_MODE_BIT];
    assign invert          = i_ctrl[`GPC_INV_BIT];
    assign level_bit       = i_ctrl[`GPC_LVL_BIT];

    // Level as software sees it, after the polarity stage
    assign o_level = i_pin_in ^ invert;

    always @* begin
        case (function_select)
            `GPC_FN_CLK_OUT:    source = i_clock_output;
            `GPC_FN_IRQ_OUT:    source = i_irq;
            `GPC_FN_PEN_DOWN:   source = i_pen_down;
            `GPC_FN_TOUCH_DONE: source = i_touch_done;
            `GPC_FN_AUX_DONE:   source = i_aux_done;
            `GPC_FN_TEMP_FLAG:  source = i_temp_flag;
            `GPC_FN_MIC_CLK:    source = i_digital_mic_clock;
            `GPC_FN_LEVEL_OUT:  source = level_bit;
            `GPC_FN_UNDERVOLT:  source = i_regulator_undervoltage;
            // Inputs and reserved codes drive nothing meaningful
            default:            source = 1'b0;
        endcase
    end

    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_pin_out     <= 1'b0;
            o_pin_oe      <= 1'b0;
            o_pull_up     <= 1'b0;
            o_pull_down   <= 1'b0;
            prev_level_ff <= 1'b0;
        end else begin
            o_pin_out     <= source ^ invert;
            o_pin_oe      <= ~direction;
            o_pull_up     <= (pull_select == `GPC_PULL_UP);
            o_pull_down   <= (pull_select == `GPC_PULL_DOWN);
            prev_level_ff <= o_level;
        end
    end

    // Rising edge of the polarity-adjusted level, or any edge in both-edge mode
    assign o_edge_event = (function_select == `GPC_FN_EDGE_IN) &&
                          (edge_mode ? (o_level ^ prev_level_ff) : (o_level & ~prev_level_ff));

endmodule // gpc_pin_slice

/* logic/gpc_pin_control.v */
// Register file and pin logic for the third and fourth general-purpose pins
`timescale 1ns/1ps
`include "gpc_regs.vh"

module gpc_pin_control (
    input  wire                   i_core_clk,
    input  wire                   i_reset,
    input  wire [`GPC_ADDR_W-1:0] i_reg_addr,
    input  wire [`GPC_DATA_W-1:0] i_reg_wdata,
    input  wire                   i_reg_write,
    input  wire                   i_reg_read,
    output reg  [`GPC_DATA_W-1:0] o_reg_rdata,
    output reg                    o_reg_rvalid,
    input  wire                   i_pin3_in,
    output wire                   o_pin3_out,
    output wire                   o_pin3_oe,
    output wire                   o_pin3_pull_up,
    output wire                   o_pin3_pull_down,
    input  wire                   i_pin4_in,
    output wire                   o_pin4_out,
    output wire                   o_pin4_oe,
    output wire                   o_pin4_pull_up,
    output wire                   o_pin4_pull_down,
    input  wire                   i_clock_output,
    input  wire                   i_irq,
    input  wire                   i_pen_down,
    input  wire                   i_touch_done,
    input  wire                   i_aux_done,
    input  wire                   i_temp_flag,
    input  wire                   i_digital_mic_clock,
    input  wire                   i_regulator_undervoltage,
    output wire                   o_pin3_irq_flag,
    output wire                   o_pin4_irq_flag
);

    localparam NUM_PINS = 2;

    reg  [15:0] pin_three_control_ff;
    reg  [15:0] pin_four_control_ff;
    reg  [NUM_PINS-1:0] irq_flag_ff;
    reg  [NUM_PINS-1:0] nxt_irq_flag;

    wire [15:0] ctrl_word  [0:NUM_PINS-1];
    wire [NUM_PINS-1:0] pin_in;
    wire [NUM_PINS-1:0] pin_out;
    wire [NUM_PINS-1:0] pin_oe;
    wire [NUM_PINS-1:0] pull_up;
    wire [NUM_PINS-1:0] pull_down;
    wire [NUM_PINS-1:0] level;
    wire [NUM_PINS-1:0] edge_event;

    wire        wr_three;
    wire        wr_four;
    wire        rd_status;
    reg  [15:0] nxt_rdata;

    // Named fields of the stored control words
    wire        pin3_direction;
    wire [1:0]  pin3_pull_select;
    wire        pin3_edge_mode;
    wire        pin3_invert;
    wire [3:0]  pin3_function_select;
    wire        pin4_direction;
    wire [1:0]  pin4_pull_select;
    wire        pin4_edge_mode;
    wire        pin4_invert;
    wire [3:0]  pin4_function_select;
    wire [15:0] pin3_readback;
    wire [15:0] pin4_readback;

    assign wr_three  = i_reg_write && (i_reg_addr == `GPC_PIN_THREE_CTRL);
    assign wr_four   = i_reg_write && (i_reg_addr == `GPC_PIN_FOUR_CTRL);
    assign rd_status = i_reg_read && (i_reg_addr == `GPC_IRQ_STATUS);

    assign ctrl_word[0] = pin_three_control_ff;
    assign ctrl_word[1] = pin_four_control_ff;
    assign pin_in       = {i_pin4_in, i_pin3_in};

    assign pin3_direction       = pin_three_control_ff[`GPC_DIR_BIT];
    assign pin3_pull_select     = pin_three_control_ff[`GPC_PULL_HI:`GPC_PULL_LO];
    assign pin3_edge_mode       = pin_three_control_ff[`GPC_MODE_BIT];
    assign pin3_invert          = pin_three_control_ff[`GPC_INV_BIT];
    assign pin3_function_select = pin_three_control_ff[`GPC_FN_HI:`GPC_FN_LO];
    assign pin4_direction       = pin_four_control_ff[`GPC_DIR_BIT];
    assign pin4_pull_select     = pin_four_control_ff[`GPC_PULL_HI:`GPC_PULL_LO];
    assign pin4_edge_mode       = pin_four_control_ff[`GPC_MODE_BIT];
    assign pin4_invert          = pin_four_control_ff[`GPC_INV_BIT];
    assign pin4_function_select = pin_four_control_ff[`GPC_FN_HI:`GPC_FN_LO];

    // Read-back words: unstored bits are zero, bit 5 is the live level after polarity
    assign pin3_readback = {pin3_direction,
                            pin3_pull_select,
                            pin3_edge_mode,
                            1'b0,
                            pin3_invert,
                            4'h0,
                            level[0],
                            1'b0,
                            pin3_function_select};
    assign pin4_readback = {pin4_direction,
                            pin4_pull_select,
                            pin4_edge_mode,
                            1'b0,
                            pin4_invert,
                            4'h0,
                            level[1],
                            1'b0,
                            pin4_function_select};

    // Control registers; bits outside the mask are not stored and read zero
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            pin_three_control_ff <= `GPC_PIN_THREE_RST;
            pin_four_control_ff  <= `GPC_PIN_FOUR_RST;
        end else begin
            if (wr_three) begin
                pin_three_control_ff <= i_reg_wdata & `GPC_CTRL_MASK;
            end
            if (wr_four) begin
                pin_four_control_ff <= i_reg_wdata & `GPC_CTRL_MASK;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
            gpc_pin_slice u_slice (
                .i_core_clk               (i_core_clk),
                .i_reset                  (i_reset),
                .i_ctrl                   (ctrl_word[g]),
                .i_pin_in                 (pin_in[g]),
                .i_clock_output           (i_clock_output),
                .i_irq                    (i_irq),
                .i_pen_down               (i_pen_down),
                .i_touch_done             (i_touch_done),
                .i_aux_done               (i_aux_done),
                .i_temp_flag              (i_temp_flag),
                .i_digital_mic_clock      (i_digital_mic_clock),
                .i_regulator_undervoltage (i_regulator_undervoltage),
                .o_pin_out                (pin_out[g]),
                .o_pin_oe                 (pin_oe[g]),
                .o_pull_up                (pull_up[g]),
                .o_pull_down              (pull_down[g]),
                .o_level                  (level[g]),
                .o_edge_event             (edge_event[g])
            );

            // A new edge in the same cycle as the clearing read stays latched
            always @* begin
                nxt_irq_flag[g] = irq_flag_ff[g];
                if (rd_status) begin
                    nxt_irq_flag[g] = 1'b0;
                end
                if (edge_event[g]) begin
                    nxt_irq_flag[g] = 1'b1;
                end
            end
        end
    endgenerate

    always @(posedge i_core_clk) begin
        if (i_reset) begin
            irq_flag_ff <= {NUM_PINS{1'b0}};
        end else begin
            irq_flag_ff <= nxt_irq_flag;
        end
    end

    // Read mux: the level bit returns the live level after polarity, not the written value
    always @* begin
        nxt_rdata = 16'h0000;
        case (i_reg_addr)
            `GPC_PIN_THREE_CTRL: begin
                nxt_rdata = pin3_readback;
            end
            `GPC_PIN_FOUR_CTRL: begin
                nxt_rdata = pin4_readback;
            end
            `GPC_IRQ_STATUS: begin
                nxt_rdata[`GPC_PIN3_FLAG_BIT] = irq_flag_ff[0];
                nxt_rdata[`GPC_PIN4_FLAG_BIT] = irq_flag_ff[1];
            end
            default: nxt_rdata = 16'h0000;
        endcase
    end

    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_reg_rdata  <= 16'h0000;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_read;
            if (i_reg_read) begin
                o_reg_rdata <= nxt_rdata;
            end
        end
    end

    assign o_pin3_out       = pin_out[0];
    assign o_pin3_oe        = pin_oe[0];
    assign o_pin3_pull_up   = pull_up[0];
    assign o_pin3_pull_down = pull_down[0];
    assign o_pin4_out       = pin_out[1];
    assign o_pin4_oe        = pin_oe[1];
    assign o_pin4_pull_up   = pull_up[1];
    assign o_pin4_pull_down = pull_down[1];
    assign o_pin3_irq_flag  = irq_flag_ff[0];
    assign o_pin4_irq_flag  = irq_flag_ff[1];

endmodule // gpc_pin_control

/* test/gpc_pin_control_props.sv */
// Concurrent checks on the pin control block's ports
`timescale 1ns/1ps
module gpc_pin_control_props (
    input logic        i_core_clk,
    input logic        i_reset,
    input logic [6:0]  i_reg_addr,
    input logic [15:0] i_reg_wdata,
    input logic        i_reg_write,
    input logic        i_reg_read,
    input logic [15:0] o_reg_rdata,
    input logic        o_reg_rvalid,
    input logic        i_pin4_in,
    input logic        o_pin4_out,
    input logic        o_pin4_oe,
    input logic        o_pin4_pull_up,
    input logic        o_pin4_pull_down,
    input logic        o_pin4_irq_flag
);
    logic [1:0] hist_ff;
    always @(posedge i_core_clk) hist_ff <= {hist_ff[0], i_pin4_in};
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    sequence s_wr4; i_reg_write && i_reg_addr == 7'h0F; endsequence
    sequence s_rdst; i_reg_read && i_reg_addr == 7'h10; endsequence
    property p_rvalid; o_reg_rvalid == $past(i_reg_read); endproperty
    property p_oe; s_wr4 |-> ##2 o_pin4_oe == !$past(i_reg_wdata[15], 2); endproperty
    property p_pull; s_wr4 |-> ##2 {o_pin4_pull_up, o_pin4_pull_down} ==
        ($past(i_reg_wdata[14:13], 2) == 2'h3 ? 2'h0 : $past(i_reg_wdata[14:13], 2)); endproperty
    property p_lvl; s_wr4 ##0 (i_reg_wdata & 16'h840F) == 16'h000A |-> ##2 o_pin4_out == $past(i_reg_wdata[5], 2);
    endproperty
    property p_inv; s_wr4 ##0 (i_reg_wdata & 16'h840F) == 16'h040C |-> ##2 o_pin4_out; endproperty
    property p_rise; $rose(o_pin4_irq_flag) |-> i_pin4_in != hist_ff[0] || hist_ff[0] != hist_ff[1]; endproperty
    property p_clr; s_rdst ##0 $stable(i_pin4_in) |=> !o_pin4_irq_flag; endproperty
    property p_stdata; s_rdst |=> (o_reg_rdata & 16'h9FFF) == 16'h0000; endproperty
    property p_ctlmask; i_reg_read && i_reg_addr[6:1] == 6'h07 |=> (o_reg_rdata & 16'h0BD0) == 16'h0000; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer not one cycle after request");
    a_oe: assert property (p_oe) else $error("output enable does not follow direction bit");
    a_pull: assert property (p_pull) else $error("pull enables do not follow pull field");
    a_lvl: assert property (p_lvl) else $error("level output does not drive written level");
    a_inv: assert property (p_inv) else $error("inverted reserved code does not drive high");
    a_rise: assert property (p_rise) else $error("flag set without pin change");
    a_clr: assert property (p_clr) else $error("status read did not clear flag");
    a_stdata: assert property (p_stdata) else $error("status read shows bits beyond the pin flags");
    a_ctlmask: assert property (p_ctlmask) else $error("unstored control bits read nonzero");
endmodule // gpc_pin_control_props

bind gpc_pin_control gpc_pin_control_props u_props (.i_core_clk, .i_reset, .i_reg_addr, .i_reg_wdata,
    .i_reg_write, .i_reg_read, .o_reg_rdata, .o_reg_rvalid, .i_pin4_in, .o_pin4_out, .o_pin4_oe,
    .o_pin4_pull_up, .o_pin4_pull_down, .o_pin4_irq_flag);

/* test/gpc_pin_host.sv */
// Far side of one pin: external driver, pull resistors, floating line
`timescale 1ns/1ps
module gpc_pin_host (
    input  logic i_clk,
    input  logic i_oe,
    input  logic i_out,
    input  logic i_up,
    input  logic i_down,
    input  logic i_drive,
    input  logic i_level,
    output logic o_pin
);
    logic wander_ff = 1'b0;
    // An undriven, unpulled line wanders so a stale value never reads as valid
    always @(posedge i_clk) wander_ff <= ~wander_ff;
    always @* begin
        if (i_oe) o_pin = i_out;
        else if (i_drive) o_pin = i_level;
        else if (i_up) o_pin = 1'b1;
        else if (i_down) o_pin = 1'b0;
        else o_pin = wander_ff;
    end
endmodule // gpc_pin_host

/* test/test_gpc_pin_control.sv */
// Self-checking bench for the pin control block
`timescale 1ns/1ps
module test_gpc_pin_control;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic        drv3 = 1'b0, lvl3 = 1'b0, drv4 = 1'b1, lvl4 = 1'b0;
    logic [6:0]  addr = 7'h00;
    logic [15:0] wdata = 16'h0000;
    logic [7:0]  src = 8'h00;
    wire  [15:0] rdata;
    wire         rvalid, p3, p3o, p3e, p3u, p3d, p4, p4o, p4e, p4u, p4d, f3, f4;
    int          n_mismatch = 0, cmp_count = 0, cycles = 0;
    logic [3:0]  fns [8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hB};
    always #10 clk = ~clk;
    gpc_pin_control i_dut (.i_core_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_pin3_in(p3),
        .o_pin3_out(p3o), .o_pin3_oe(p3e), .o_pin3_pull_up(p3u), .o_pin3_pull_down(p3d), .i_pin4_in(p4),
        .o_pin4_out(p4o), .o_pin4_oe(p4e), .o_pin4_pull_up(p4u), .o_pin4_pull_down(p4d),
        .i_clock_output(src[0]), .i_irq(src[1]), .i_pen_down(src[2]), .i_touch_done(src[3]),
        .i_aux_done(src[4]), .i_temp_flag(src[5]), .i_digital_mic_clock(src[6]),
        .i_regulator_undervoltage(src[7]), .o_pin3_irq_flag(f3), .o_pin4_irq_flag(f4));
    gpc_pin_host u_host3 (.i_clk(clk), .i_oe(p3e), .i_out(p3o), .i_up(p3u), .i_down(p3d), .i_drive(drv3),
        .i_level(lvl3), .o_pin(p3));
    gpc_pin_host u_host4 (.i_clk(clk), .i_oe(p4e), .i_out(p4o), .i_up(p4u), .i_down(p4d), .i_drive(drv4),
        .i_level(lvl4), .o_pin(p4));
    task close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            close_out();
        end
    end
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task chkb(input string n, input logic e, input logic g);
        chk(n, {15'h0000, e}, {15'h0000, g});
    endtask
    task wrw(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
        // Stored at the strobe edge, pins follow one edge later
        repeat (2) @(posedge clk);
        #1;
    endtask
    task rdw(input logic [6:0] a, input logic [15:0] e);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 chkb("rvalid", 1'b1, rvalid);
        chk("rdata", e, rdata);
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task t_reset;
        rdw(7'h0E, 16'hC020);
        chk("pull3", 16'h0002, {14'h0000, p3u, p3d});
        rdw(7'h0F, 16'h8000);
        rdw(7'h10, 16'h0000);
        rdw(7'h20, 16'h0000);
        wrw(7'h0E, 16'h002A);
        chkb("out3", 1'b1, p3o);
        wrw(7'h0E, 16'h0000);
        chkb("oe3", 1'b1, p3e);
        chkb("out3", 1'b0, p3o);
        chk("pull3", 16'h0000, {14'h0000, p3u, p3d});
    endtask
    task t_route;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) src <= 8'h01 << i;
            wrw(7'h0F, {12'h000, fns[i]});
            chkb("route", 1'b1, p4o);
            @(posedge clk) src <= ~(8'h01 << i);
            settle();
            chkb("route", 1'b0, p4o);
        end
        wrw(7'h0F, 16'h002A);
        chkb("lvl_out", 1'b1, p4o);
        wrw(7'h0F, 16'h040C);
        chkb("inv_rsv", 1'b1, p4o);
        wrw(7'h0F, 16'h0008);
        chkb("rsv", 1'b0, p4o);
    endtask
    task t_pull;
        for (int p = 0; p < 4; p++) begin
            wrw(7'h0F, {1'b1, p[1:0], 13'h0000});
            chk("pull", {14'h0000, p == 2, p == 1}, {14'h0000, p4u, p4d});
            chkb("oe4", 1'b0, p4e);
        end
    endtask
    task t_level;
        lvl4 <= 1'b1;
        wrw(7'h0F, 16'h8000);
        rdw(7'h0F, 16'h8020);
        wrw(7'h0F, 16'h8400);
        rdw(7'h0F, 16'h8400);
    endtask
    task t_edge;
        lvl4 <= 1'b0;
        wrw(7'h0F, 16'h8001);
        lvl4 <= 1'b1;
        settle();
        chkb("flag4", 1'b1, f4);
        rdw(7'h10, 16'h4000);
        chkb("flag4", 1'b0, f4);
        lvl4 <= 1'b0;
        settle();
        rdw(7'h10, 16'h0000);
        wrw(7'h0F, 16'h9001);
        lvl4 <= 1'b1;
        settle();
        rdw(7'h10, 16'h4000);
        lvl4 <= 1'b0;
        settle();
        rdw(7'h10, 16'h4000);
        // Raise the pin before inverting so the polarity change makes no rising edge
        lvl4 <= 1'b1;
        wrw(7'h0F, 16'h8401);
        rdw(7'h10, 16'h4000);
        lvl4 <= 1'b0;
        settle();
        rdw(7'h10, 16'h4000);
        lvl4 <= 1'b1;
        settle();
        rdw(7'h10, 16'h0000);
        drv3 <= 1'b1;
        wrw(7'h0E, 16'h8001);
        lvl3 <= 1'b1;
        settle();
        chkb("flag3", 1'b1, f3);
        rdw(7'h10, 16'h2000);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_route();
        t_pull();
        t_level();
        t_edge();
        close_out();
    end
endmodule // test_gpc_pin_control
